// ===== logic/ihbs_sequencer.sv
/*
 * ihbs_sequencer: i2c host bus sequencer with start, repeated start,
 * stop, byte transmit, byte receive and acknowledge sequences.
 * Assumes: open-drain lines resolved outside; register port master on clk.
 */
// Contract
// - buffer write while busy sets collision, no store
// - sequence request bits locked until every requested sequence completes or a collision clears them
// - start with both lines high reloads generator
// - timeout pulls data low, flags start, holds
// - low lines at start: collision, abort, idle
// - repeated start ignored while another event runs
// - repeated start: clock low, release data, release clock
// - both high one period, data low, clock low
// - start flag at once, irq after timeout
// - repeated start collision on data low or clock
// - idle buffer write sets full, shifts msb first
// - clock low/high one period, data stable high
// - eighth fall clears full, releases data
// - ninth clock samples acknowledge into status
// - after ninth clock irq, suspend, clock low
// - receive request ignored unless idle
// - reception toggles clock, shifts sampled data in
// - eighth received fall loads buffer if not full, flags, idles
// - reading buffer outside a transmit clears full flag
// - full byte while buffer full sets overflow
// - released clock waits sampled high, then counts
// - ack sequence drives ack bit, one period
`timescale 1ns/100ps
module ihbs_sequencer
	import ihbs_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	input  wire ihbs_pkg::ihbs_bus_req_type bus_req,
	output logic [7:0]                      bus_rdata,
	input  wire ihbs_pkg::ihbs_pin_in_type  pin_in,
	output ihbs_pkg::ihbs_pin_out_type      pin_out
);
	import ihbs_pkg::*;

	ihbs_state_type state_r;
	ihbs_state_type state_nxt;
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic       scl_s;
	logic       sda_s;
	logic       scl_drv_r;
	logic       sda_drv_r;
	logic       scl_drv_nxt;
	logic       sda_drv_nxt;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [7:0] xfer_buffer_r;
	logic [7:0] baud_r;
	logic [4:0] req_r;
	logic [4:0] req_clr;
	logic       ack_data_r;
	logic       ack_status_r;
	logic       ack_status_nxt;
	logic       bf_r;
	logic       sdet_r;
	logic       write_collision_flag_r;
	logic       ovf_r;
	logic       irq_r;
	logic       bcol_r;
	logic [7:0] rdata_r;
	logic       bg_load;
	logic       bg_run;
	logic       tick;
	logic       set_sdet;
	logic       set_irq;
	logic       set_bcol;
	logic       set_ovf;
	logic       bf_clr_hw;
	logic       rx_done;

	// two-flop synchronisers on the bus lines
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
		end else begin
			scl_sync_r <= {scl_sync_r[0], pin_in.scl};
			sda_sync_r <= {sda_sync_r[0], pin_in.sda};
		end
	end
	assign scl_s = scl_sync_r[1];
	assign sda_s = sda_sync_r[1];

	// register port decode
	wire hit_xfer   = bus_req.addr == IHBS_XFER_OFS;
	wire hit_ctrl   = bus_req.addr == IHBS_CTRL2_OFS;
	wire hit_status = bus_req.addr == IHBS_STATUS_OFS;
	wire hit_baud   = bus_req.addr == IHBS_BAUD_OFS;
	wire idle_ok    = (state_r == IHBS_IDLE) && (req_r == IHBS_REQ_RST);
	wire busy       = !idle_ok;
	wire buf_wr     = bus_req.wr && hit_xfer;
	wire tx_go      = buf_wr && idle_ok;
	wire write_collision_flag_set   = buf_wr && busy;
	wire ctrl_wr_ok = bus_req.wr && hit_ctrl && idle_ok;
	wire tx_act     = (state_r == IHBS_TX_LOW) ||
	                  (state_r == IHBS_TX_WAIT) ||
	                  (state_r == IHBS_TX_HIGH);
	wire buf_rd_clr = bus_req.rd && hit_xfer && !tx_act;
	wire [4:0] w1c  = (bus_req.wr && hit_status) ? bus_req.wdata[5:1] : 5'h00;
	wire [7:0] status_word = {2'h0, bcol_r, irq_r, ovf_r, write_collision_flag_r,
	                          sdet_r, bf_r};
	wire [7:0] ctrl_word   = {1'b0, ack_status_r, ack_data_r, req_r};
	wire [7:0] rdata_nxt   = !bus_req.rd ? 8'h00 :
	                         hit_xfer    ? xfer_buffer_r :
	                         hit_ctrl    ? ctrl_word :
	                         hit_status  ? status_word :
	                         hit_baud    ? baud_r : 8'h00;

	ihbs_baud_gen #(
		.WIDTH (8)
	) u_baud (
		.clk     (clk),
		.reset_n (reset_n),
		.reload  (baud_r),
		.load    (bg_load),
		.run     (bg_run),
		.tick    (tick)
	);

	// sequencer: one bus phase per state, paced by the generator
	always_comb begin
		state_nxt      = state_r;
		scl_drv_nxt    = scl_drv_r;
		sda_drv_nxt    = sda_drv_r;
		bit_nxt        = bit_r;
		shift_nxt      = shift_r;
		ack_status_nxt = ack_status_r;
		req_clr        = 5'h00;
		bg_load        = 1'b0;
		bg_run         = 1'b1;
		set_sdet       = 1'b0;
		set_irq        = 1'b0;
		set_bcol       = 1'b0;
		set_ovf        = 1'b0;
		bf_clr_hw      = 1'b0;
		rx_done        = 1'b0;
		case (state_r)
			IHBS_IDLE: begin
				bg_run = 1'b0;
				if (tx_go) begin
					shift_nxt   = bus_req.wdata;
					bit_nxt     = 4'h0;
					scl_drv_nxt = 1'b1;
					sda_drv_nxt = !bus_req.wdata[7];
					bg_load     = 1'b1;
					state_nxt   = IHBS_TX_LOW;
				end else if (req_r[IHBS_START_BIT]) begin
					if (scl_s && sda_s) begin
						bg_load   = 1'b1;
						state_nxt = IHBS_ST_WAIT;
					end else begin
						set_bcol = 1'b1;
						req_clr  = 5'h1f;
					end
				end else if (req_r[IHBS_RSTRT_BIT]) begin
					scl_drv_nxt = 1'b1;
					state_nxt   = IHBS_RS_LOW;
				end else if (req_r[IHBS_STOP_BIT]) begin
					scl_drv_nxt = 1'b1;
					sda_drv_nxt = 1'b1;
					bg_load     = 1'b1;
					state_nxt   = IHBS_SP_LOW;
				end else if (req_r[IHBS_RCV_BIT]) begin
					scl_drv_nxt = 1'b1;
					sda_drv_nxt = 1'b0;
					bit_nxt     = 4'h0;
					bg_load     = 1'b1;
					state_nxt   = IHBS_RX_LOW;
				end else if (req_r[IHBS_ACKSQ_BIT]) begin
					scl_drv_nxt = 1'b1;
					sda_drv_nxt = !ack_data_r;
					bg_load     = 1'b1;
					state_nxt   = IHBS_AK_LOW;
				end
			end
			IHBS_ST_WAIT: begin
				if (!scl_s) begin
					set_bcol  = 1'b1;
					req_clr   = 5'h1f;
					state_nxt = IHBS_IDLE;
				end else if (tick && sda_s) begin
					sda_drv_nxt = 1'b1;
					set_sdet    = 1'b1;
					state_nxt   = IHBS_ST_HOLD;
				end
			end
			IHBS_ST_HOLD: if (tick) begin
				req_clr[IHBS_START_BIT] = 1'b1;
				set_irq   = 1'b1;
				state_nxt = IHBS_IDLE;
			end
			IHBS_RS_LOW: begin
				bg_run = 1'b0;
				if (!scl_s) begin
					sda_drv_nxt = 1'b0;
					bg_load     = 1'b1;
					state_nxt   = IHBS_RS_REL;
				end
			end
			IHBS_RS_REL: if (tick) begin
				if (sda_s) begin
					scl_drv_nxt = 1'b0;
					state_nxt   = IHBS_RS_RISE;
				end else begin
					set_bcol    = 1'b1;
					req_clr     = 5'h1f;
					scl_drv_nxt = 1'b0;
					state_nxt   = IHBS_IDLE;
				end
			end
			IHBS_RS_RISE: begin
				bg_run = 1'b0;
				if (scl_s && !sda_s) begin
					set_bcol  = 1'b1;
					req_clr   = 5'h1f;
					state_nxt = IHBS_IDLE;
				end else if (scl_s) begin
					bg_load   = 1'b1;
					state_nxt = IHBS_RS_HIGH;
				end
			end
			IHBS_RS_HIGH: begin
				if (!scl_s || !sda_s) begin
					set_bcol  = 1'b1;
					req_clr   = 5'h1f;
					state_nxt = IHBS_IDLE;
				end else if (tick) begin
					sda_drv_nxt = 1'b1;
					set_sdet    = 1'b1;
					state_nxt   = IHBS_RS_SDA;
				end
			end
			IHBS_RS_SDA: if (tick) begin
				scl_drv_nxt = 1'b1;
				req_clr[IHBS_RSTRT_BIT] = 1'b1;
				set_irq   = 1'b1;
				state_nxt = IHBS_IDLE;
			end
			IHBS_TX_LOW: if (tick) begin
				scl_drv_nxt = 1'b0;
				state_nxt   = IHBS_TX_WAIT;
			end
			IHBS_TX_WAIT: begin
				bg_run = 1'b0;
				if (scl_s) begin
					bg_load   = 1'b1;
					state_nxt = IHBS_TX_HIGH;
					if (bit_r == IHBS_ACK_BIT) begin
						ack_status_nxt = sda_s;
					end
				end
			end
			IHBS_TX_HIGH: if (tick) begin
				scl_drv_nxt = 1'b1;
				state_nxt   = IHBS_TX_LOW;
				if (bit_r == IHBS_ACK_BIT) begin
					set_irq   = 1'b1;
					state_nxt = IHBS_IDLE;
				end else if (bit_r == IHBS_LAST_BIT) begin
					bf_clr_hw   = 1'b1;
					sda_drv_nxt = 1'b0;
					bit_nxt     = IHBS_ACK_BIT;
				end else begin
					shift_nxt   = {shift_r[6:0], 1'b0};
					sda_drv_nxt = !shift_r[6];
					bit_nxt     = bit_r + 4'h1;
				end
			end
			IHBS_RX_LOW: if (tick) begin
				scl_drv_nxt = 1'b0;
				state_nxt   = IHBS_RX_WAIT;
			end
			IHBS_RX_WAIT: begin
				bg_run = 1'b0;
				if (scl_s) begin
					shift_nxt = {shift_r[6:0], sda_s};
					bg_load   = 1'b1;
					state_nxt = IHBS_RX_HIGH;
				end
			end
			IHBS_RX_HIGH: if (tick) begin
				scl_drv_nxt = 1'b1;
				state_nxt   = IHBS_RX_LOW;
				bit_nxt     = bit_r + 4'h1;
				if (bit_r == IHBS_LAST_BIT) begin
					rx_done = 1'b1;
					set_ovf = bf_r;
					set_irq = 1'b1;
					req_clr[IHBS_RCV_BIT] = 1'b1;
					state_nxt = IHBS_IDLE;
				end
			end
			IHBS_AK_LOW: if (tick) begin
				scl_drv_nxt = 1'b0;
				state_nxt   = IHBS_AK_WAIT;
			end
			IHBS_AK_WAIT: begin
				bg_run = 1'b0;
				if (scl_s) begin
					bg_load   = 1'b1;
					state_nxt = IHBS_AK_HIGH;
				end
			end
			IHBS_AK_HIGH: if (tick) begin
				scl_drv_nxt = 1'b1;
				sda_drv_nxt = 1'b0;
				req_clr[IHBS_ACKSQ_BIT] = 1'b1;
				set_irq   = 1'b1;
				state_nxt = IHBS_IDLE;
			end
			IHBS_SP_LOW: if (tick) begin
				scl_drv_nxt = 1'b0;
				state_nxt   = IHBS_SP_WAIT;
			end
			IHBS_SP_WAIT: begin
				bg_run = 1'b0;
				if (scl_s) begin
					bg_load   = 1'b1;
					state_nxt = IHBS_SP_HIGH;
				end
			end
			IHBS_SP_HIGH: if (tick) begin
				sda_drv_nxt = 1'b0;
				state_nxt   = IHBS_SP_REL;
			end
			IHBS_SP_REL: if (tick) begin
				req_clr[IHBS_STOP_BIT] = 1'b1;
				set_irq   = 1'b1;
				state_nxt = IHBS_IDLE;
			end
			default: state_nxt = IHBS_IDLE;
		endcase
		if (set_bcol) begin
			scl_drv_nxt = 1'b0;
			sda_drv_nxt = 1'b0;
			bf_clr_hw   = 1'b1;
		end
	end

	// flags: hardware set wins over software clear
	wire [4:0] req_nxt = ctrl_wr_ok ? bus_req.wdata[4:0] : (req_r & ~req_clr);
	wire bf_nxt   = (bf_r & ~(bf_clr_hw | buf_rd_clr)) | tx_go | rx_done;
	wire sdet_nxt = (sdet_r & ~w1c[0]) | set_sdet;
	wire write_collision_flag_nxt = (write_collision_flag_r & ~w1c[1]) | write_collision_flag_set;
	wire ovf_nxt  = (ovf_r  & ~w1c[2]) | set_ovf;
	wire irq_nxt  = (irq_r  & ~w1c[3]) | set_irq;
	wire bcol_nxt = (bcol_r & ~w1c[4]) | set_bcol;
	wire [7:0] buf_nxt = tx_go             ? bus_req.wdata :
	                     (rx_done && !bf_r) ? shift_r : xfer_buffer_r;

	// sequencer and line registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r      <= IHBS_IDLE;
			scl_drv_r    <= 1'b0;
			sda_drv_r    <= 1'b0;
			bit_r        <= 4'h0;
			shift_r      <= IHBS_BYTE_RST;
			ack_status_r <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			scl_drv_r    <= scl_drv_nxt;
			sda_drv_r    <= sda_drv_nxt;
			bit_r        <= bit_nxt;
			shift_r      <= shift_nxt;
			ack_status_r <= ack_status_nxt;
		end
	end

	// software-visible registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			xfer_buffer_r <= IHBS_BYTE_RST;
			baud_r        <= IHBS_BAUD_RST;
			req_r         <= IHBS_REQ_RST;
			ack_data_r    <= 1'b0;
			{bf_r, sdet_r, write_collision_flag_r, ovf_r, irq_r, bcol_r} <= 6'h00;
			rdata_r       <= 8'h00;
		end else begin
			xfer_buffer_r <= buf_nxt;
			req_r         <= req_nxt;
			{bf_r, sdet_r, write_collision_flag_r, ovf_r, irq_r, bcol_r} <=
				{bf_nxt, sdet_nxt, write_collision_flag_nxt, ovf_nxt, irq_nxt, bcol_nxt};
			rdata_r       <= rdata_nxt;
			if (bus_req.wr && hit_baud) begin
				baud_r <= bus_req.wdata;
			end
			if (bus_req.wr && hit_ctrl) begin
				ack_data_r <= bus_req.wdata[IHBS_ACKDT_BIT];
			end
		end
	end

	// open-drain outputs: enable high means pulling low
	assign pin_out   = '{scl_o: 1'b0, scl_oe: scl_drv_r,
	                     sda_o: 1'b0, sda_oe: sda_drv_r};
	assign bus_rdata = rdata_r;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence tx_ninth_s;
		state_r == IHBS_TX_HIGH && tick && bit_r == IHBS_ACK_BIT;
	endsequence
	sequence rx_eighth_s;
		state_r == IHBS_RX_HIGH && tick && bit_r == IHBS_LAST_BIT;
	endsequence

	write_collision_flag_keep_a: assert property (write_collision_flag_set |=> write_collision_flag_r &&
		xfer_buffer_r == $past(xfer_buffer_r)) else $error("buffer changed");
	ctrl_lock_a: assert property (bus_req.wr && hit_ctrl && busy |=>
		(req_r & ~$past(req_r)) == 5'h00) else $error("request taken busy");
	start_load_a: assert property (state_r == IHBS_IDLE && !tx_go &&
		req_r == 5'h01 && scl_s && sda_s |=> state_r == IHBS_ST_WAIT)
		else $error("start not begun");
	start_det_a: assert property (state_r == IHBS_ST_WAIT && scl_s &&
		sda_s && tick |=> sda_drv_r && sdet_r ##1 sda_drv_r)
		else $error("start edge missing");
	start_bcol_a: assert property (state_r == IHBS_ST_WAIT && !scl_s
		|=> bcol_r && state_r == IHBS_IDLE && !sda_drv_r)
		else $error("start collision missed");
	rs_irq_a: assert property (state_r == IHBS_RS_SDA && !tick &&
		!irq_r |=> !irq_r) else $error("early irq");
	tx_stable_a: assert property (tx_act && !scl_drv_r &&
		$past(!scl_drv_r) |-> $stable(sda_drv_r))
		else $error("data moved clock high");
	bf_clear_a: assert property (state_r == IHBS_TX_HIGH && tick &&
		bit_r == IHBS_LAST_BIT |=> !bf_r && !sda_drv_r && scl_drv_r)
		else $error("eighth fall wrong");
	ack_samp_a: assert property (state_r == IHBS_TX_WAIT && scl_s &&
		bit_r == IHBS_ACK_BIT |=> ack_status_r == $past(sda_s))
		else $error("ack not sampled");
	tx_done_a: assert property (tx_ninth_s |=> irq_r &&
		state_r == IHBS_IDLE && scl_drv_r && !sda_drv_r ##1 !tick)
		else $error("ninth clock end wrong");
	rcv_ign_a: assert property (bus_req.wr && hit_ctrl && busy &&
		!req_r[IHBS_RCV_BIT] |=> !req_r[IHBS_RCV_BIT])
		else $error("receive taken busy");
	rx_done_a: assert property ((rx_eighth_s and !bf_r) |=> bf_r &&
		irq_r && scl_drv_r && state_r == IHBS_IDLE &&
		xfer_buffer_r == $past(shift_r)) else $error("rx end wrong");
	rd_clr_a: assert property (buf_rd_clr && !rx_done |=> !bf_r)
		else $error("read kept full");
	ovf_set_a: assert property ((rx_eighth_s and bf_r) |=> ovf_r)
		else $error("overflow missed");
	stretch_a: assert property (state_r == IHBS_TX_WAIT && !scl_s
		|=> state_r == IHBS_TX_WAIT && !tick) else $error("no stretch");

endmodule : ihbs_sequencer

// ===== logic/ihbs_pkg.sv
/*
 * ihbs_pkg: shared constants and carrier types of the i2c host bus
 * sequencer, a register map, field positions, reset values and the
 * packed structs for the register port and the two bus lines.
 * Assumes: the register port is 8 bits wide with byte addresses.
 */
package ihbs_pkg;

	// register offsets (byte addresses)
	localparam logic [7:0] IHBS_XFER_OFS   = 8'h00;
	localparam logic [7:0] IHBS_CTRL2_OFS  = 8'h04;
	localparam logic [7:0] IHBS_STATUS_OFS = 8'h08;
	localparam logic [7:0] IHBS_BAUD_OFS   = 8'h0c;

	// control_reg_two bit positions
	localparam int IHBS_START_BIT = 0;
	localparam int IHBS_RSTRT_BIT = 1;
	localparam int IHBS_STOP_BIT  = 2;
	localparam int IHBS_RCV_BIT   = 3;
	localparam int IHBS_ACKSQ_BIT = 4;
	localparam int IHBS_ACKDT_BIT = 5;
	localparam int IHBS_ACKST_BIT = 6;

	// status_reg bit positions (1..5 write one to clear)
	localparam int IHBS_BF_BIT   = 0;
	localparam int IHBS_SDET_BIT = 1;
	localparam int IHBS_WRITE_COLLISION_FLAG_BIT = 2;
	localparam int IHBS_OVF_BIT  = 3;
	localparam int IHBS_IRQ_BIT  = 4;
	localparam int IHBS_BCOL_BIT = 5;

	// values after reset
	localparam logic [7:0] IHBS_BAUD_RST = 8'h04;
	localparam logic [7:0] IHBS_BYTE_RST = 8'h00;
	localparam logic [4:0] IHBS_REQ_RST  = 5'h00;

	// bit counts of a byte transfer
	localparam logic [3:0] IHBS_LAST_BIT = 4'h7;
	localparam logic [3:0] IHBS_ACK_BIT  = 4'h8;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ihbs_bus_req_type;

	typedef struct packed {
		logic scl;
		logic sda;
	} ihbs_pin_in_type;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} ihbs_pin_out_type;

	typedef enum logic [4:0] {
		IHBS_IDLE, IHBS_ST_WAIT, IHBS_ST_HOLD,
		IHBS_RS_LOW, IHBS_RS_REL, IHBS_RS_RISE, IHBS_RS_HIGH, IHBS_RS_SDA,
		IHBS_TX_LOW, IHBS_TX_WAIT, IHBS_TX_HIGH,
		IHBS_RX_LOW, IHBS_RX_WAIT, IHBS_RX_HIGH,
		IHBS_AK_LOW, IHBS_AK_WAIT, IHBS_AK_HIGH,
		IHBS_SP_LOW, IHBS_SP_WAIT, IHBS_SP_HIGH, IHBS_SP_REL
	} ihbs_state_type;

endpackage : ihbs_pkg

// ===== logic/ihbs_baud_gen.sv
/*
 * ihbs_baud_gen: reloadable down counter that paces each timed bus phase; held while the sequencer waits on the clock line.
 * Assumes: load and run come from the sequencer on the same clock.
 */
`timescale 1ns/100ps
module ihbs_baud_gen #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] reload,
	input  wire logic             load,
	input  wire logic             run,
	output logic                  tick
);
	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;

	// one period is reload+1 cycles; rollover reloads by itself
	assign tick    = run && !load && (cnt_r == '0);
	assign cnt_nxt = load ? reload :
	                 tick ? reload :
	                 run  ? cnt_r - 1'b1 : cnt_r;

	// counter register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : ihbs_baud_gen

// ===== sim/ihbs_client_model.sv
/*
 * ihbs_client_model: behavioural i2c client on the pulled-up lines.
 * Assumes: the bench resolves both lines; the client never stretches.
 */
`timescale 1ns/100ps
module ihbs_client_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       rd_mode,
	input  wire logic [7:0] rx_byte,
	input  wire logic       nack,
	input  wire logic       hold_sda,
	output logic            sda_oe,
	output logic [7:0]      got_byte
);
	logic [3:0] wcnt = 4'h0;
	logic [3:0] rcnt = 4'h0;
	logic [7:0] sh = 8'h00;
	logic       ack_drv = 1'b0;

	// a start condition restarts the bit count
	always @(negedge sda) begin
		if (scl) wcnt = 4'h0;
	end

	// host bits taken at each clock rise, msb first
	always @(posedge scl) begin
		if (!rd_mode) begin
			if (wcnt < 4'h8) sh = {sh[6:0], sda};
			wcnt = wcnt + 4'h1;
		end
	end

	// answer the ninth bit after the eighth fall, then let go
	always @(negedge scl) begin
		ack_drv = !rd_mode && wcnt == 4'h8 && !nack;
		if (wcnt == 4'h9) wcnt = 4'h0;
		if (rd_mode && rcnt < 4'h8) rcnt = rcnt + 4'h1;
	end

	// a new reception starts from the top bit
	always @(posedge rd_mode) begin
		rcnt = 4'h0;
	end

	// data moves only while clock is low; released lines float high
	assign got_byte = sh;
	assign sda_oe = hold_sda | ack_drv
		| (rd_mode && rcnt < 4'h8 && !rx_byte[3'h7 - rcnt[2:0]]);
endmodule : ihbs_client_model

// ===== sim/test_i2c_host_bus_sequencer.sv
/*
 * test_i2c_host_bus_sequencer: self-checking bench of ihbs_sequencer.
 * Assumes: pull-ups on both lines, client model on the far side.
 */
`timescale 1ns/100ps
module test_i2c_host_bus_sequencer;
	import ihbs_pkg::*;
	logic             clk;
	logic             reset_n;
	ihbs_bus_req_type req;
	logic [7:0]       rdata;
	ihbs_pin_in_type  pin_in;
	ihbs_pin_out_type pin_out;
	logic             rd_mode, nack, hold_sda, cli_oe, scl_ln, sda_ln;
	logic [7:0]       rx_byte, got_byte, st, d;
	int               bad_count, total_checks;

	// open-drain lines with pull-ups
	assign scl_ln = ~pin_out.scl_oe;
	assign sda_ln = ~(pin_out.sda_oe | cli_oe);
	assign pin_in = {scl_ln, sda_ln};

	ihbs_sequencer uut (.clk(clk), .reset_n(reset_n), .bus_req(req),
		.bus_rdata(rdata), .pin_in(pin_in), .pin_out(pin_out));
	ihbs_client_model cli (.scl(scl_ln), .sda(sda_ln),
		.rd_mode(rd_mode), .rx_byte(rx_byte), .nack(nack),
		.hold_sda(hold_sda), .sda_oe(cli_oe), .got_byte(got_byte));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk) req <= {1'b1, 1'b0, a, v};
		@(posedge clk) req <= '0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk) req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk) req <= '0;
		#1 v = rdata;
	endtask : rd

	// poll status until a flag shows, bounded
	task automatic wait_flag(input logic [7:0] m, output int n);
		n = 0;
		st = 8'h00;
		while ((st & m) === 8'h00 && n < 500) begin
			rd(IHBS_STATUS_OFS, st);
			n++;
		end
	endtask : wait_flag

	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
	endtask : do_reset

	task automatic t_reset();
		rd(IHBS_STATUS_OFS, d);
		chk(d, 8'h00);
		rd(IHBS_BAUD_OFS, d);
		chk(d, IHBS_BAUD_RST);
		wr(8'h10, 8'h77);
		rd(8'h10, d);
		chk(d, 8'h00);
		chk({6'h0, scl_ln, sda_ln}, 8'h03);
		chk({6'h0, pin_out.scl_o, pin_out.sda_o}, 8'h00);
	endtask : t_reset

	// start with a locked request and a dropped buffer write
	task automatic t_start();
		int n;
		wr(IHBS_BAUD_OFS, 8'h1f);
		wr(IHBS_CTRL2_OFS, 8'h01);
		wr(IHBS_CTRL2_OFS, 8'h08);
		wr(IHBS_XFER_OFS, 8'h55);
		wait_flag(8'h10, n);
		chk(st, 8'h16);
		chk({7'h0, n >= 28 && n <= 38}, 8'h01);
		rd(IHBS_CTRL2_OFS, d);
		chk(d, 8'h00);
		chk({6'h0, scl_ln, sda_ln}, 8'h02);
		wr(IHBS_STATUS_OFS, 8'h3e);
	endtask : t_start

	// one byte out, requests made mid-byte are dropped
	task automatic t_tx(input logic [7:0] b, input logic nk);
		int n;
		nack = nk;
		wr(IHBS_XFER_OFS, b);
		rd(IHBS_STATUS_OFS, d);
		chk(d, 8'h01);
		wr(IHBS_XFER_OFS, ~b);
		wr(IHBS_CTRL2_OFS, 8'h0a);
		wait_flag(8'h10, n);
		chk(st, 8'h14);
		chk(got_byte, b);
		rd(IHBS_CTRL2_OFS, d);
		chk(d, {1'b0, nk, 6'h00});
		chk({6'h0, scl_ln, sda_ln}, 8'h01);
		wr(IHBS_STATUS_OFS, 8'h14);
	endtask : t_tx

	task automatic rx(input logic [7:0] b);
		int n;
		@(posedge clk); // let the model see its mode drop first
		rx_byte = b;
		rd_mode = 1'b1;
		wr(IHBS_CTRL2_OFS, 8'h08);
		wait_flag(8'h10, n);
		rd(IHBS_CTRL2_OFS, d);
		chk(d & 8'h1f, 8'h00);
		chk({6'h0, scl_ln, sda_ln}, 8'h01);
		wr(IHBS_STATUS_OFS, 8'h10);
		rd_mode = 1'b0;
	endtask : rx

	// reception, buffer read, then overflow on an unread byte
	task automatic t_recv();
		rx(8'hc3);
		chk(st, 8'h11);
		rd(IHBS_XFER_OFS, d);
		chk(d, 8'hc3);
		rd(IHBS_STATUS_OFS, d);
		chk(d, 8'h00);
		rx(8'h5a);
		rx(8'h96);
		chk(st, 8'h19);
		rd(IHBS_XFER_OFS, d);
		chk(d, 8'h5a);
		wr(IHBS_STATUS_OFS, 8'h08);
	endtask : t_recv

	task automatic t_ack(input logic a);
		int n;
		wr(IHBS_CTRL2_OFS, {2'b00, a, 5'h10});
		wait_flag(8'h10, n);
		chk({7'h0, got_byte[0]}, {7'h0, a});
		rd(IHBS_CTRL2_OFS, d);
		chk(d & 8'h1f, 8'h00);
		wr(IHBS_STATUS_OFS, 8'h10);
	endtask : t_ack

	task automatic t_rstart();
		int n;
		wr(IHBS_CTRL2_OFS, 8'h02);
		wait_flag(8'h10, n);
		chk(st, 8'h12);
		rd(IHBS_CTRL2_OFS, d);
		chk(d & 8'h1f, 8'h00);
		chk({6'h0, scl_ln, sda_ln}, 8'h00);
		wr(IHBS_STATUS_OFS, 8'h12);
	endtask : t_rstart

	// stop ends the transfer with both lines released
	task automatic t_stop();
		int n;
		wr(IHBS_CTRL2_OFS, 8'h04);
		wait_flag(8'h10, n);
		chk(st, 8'h10);
		rd(IHBS_CTRL2_OFS, d);
		chk(d & 8'h1f, 8'h00);
		chk({6'h0, scl_ln, sda_ln}, 8'h03);
		wr(IHBS_STATUS_OFS, 8'h10);
	endtask : t_stop

	// second reset, then a start while data is held low
	task automatic t_coll();
		int n;
		hold_sda = 1'b1;
		do_reset();
		wr(IHBS_CTRL2_OFS, 8'h01);
		wait_flag(8'h20, n);
		chk(st, 8'h20);
		rd(IHBS_CTRL2_OFS, d);
		chk(d, 8'h00);
		hold_sda = 1'b0;
		wr(IHBS_STATUS_OFS, 8'h20);
		wr(IHBS_XFER_OFS, 8'h81);
		rd(IHBS_STATUS_OFS, d);
		chk(d, 8'h01);
	endtask : t_coll

	task automatic tally_and_finish();
		if (bad_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// main sequence
	initial begin
		req = '0;
		reset_n = 1'b0;
		rd_mode = 1'b0;
		nack = 1'b0;
		hold_sda = 1'b0;
		rx_byte = 8'h00;
		bad_count = 0;
		total_checks = 0;
		do_reset();
		t_reset();
		t_start();
		t_tx(8'ha5, 1'b0);
		t_tx(8'h3c, 1'b1);
		t_recv();
		t_ack(1'b0);
		t_ack(1'b1);
		t_rstart();
		t_stop();
		t_coll();
		tally_and_finish();
	end

	// watchdog well past the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
endmodule : test_i2c_host_bus_sequencer
